// ==== rtl/image_xfer_pkg.sv ====
package image_xfer_pkg;

  // ***********************************
  // bus and register map
  // ***********************************
  localparam int ADDR_W = 12;  // byte address width seen by the slave
  localparam int IDX_W = 10;  // register index width, byte address is four times it
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h001;
  localparam logic [IDX_W-1:0] IDX_DEST_HI = 10'h042;
  localparam logic [IDX_W-1:0] IDX_DEST_LO = 10'h043;
  localparam logic [IDX_W-1:0] IDX_SIZE_X = 10'h046;
  localparam logic [IDX_W-1:0] IDX_SIZE_Y = 10'h047;
  localparam logic [IDX_W-1:0] IDX_ENTRY = 10'h048;
  localparam logic [IDX_W-1:0] IDX_DMA_HI = 10'h050;
  localparam logic [IDX_W-1:0] IDX_DMA_LO = 10'h051;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***********************************
  // field layout and reset values
  // ***********************************
  localparam int WORD_W = 16;  // one image word
  localparam int DEST_HI_W = 7;
  localparam int DEST_LO_W = 15;
  localparam int DEST_LO_LSB = 1;
  localparam int SIZE_X_W = 11;
  localparam int SIZE_Y_W = 10;
  localparam int DMA_HI_W = 3;
  localparam int PTR_W = DEST_HI_W + DEST_LO_W;  // word address A22..A1
  localparam int PIX_W = 22;  // room for twice x times y
  localparam int CTRL_CONV_LSB = 0;
  localparam int CTRL_DMA_LSB = 4;
  localparam int CTRL_BUSY_BIT = 8;
  localparam logic [WORD_W-1:0] REG_RST = 16'h0000;
  localparam int FIFO_DEPTH = 32;

  // ***********************************
  // mode encodings and states
  // ***********************************
  localparam logic [2:0] CONV_OFF = 3'h0;
  localparam logic [2:0] CONV_MODE_A = 3'h1;
  localparam logic [2:0] CONV_MODE_B = 3'h2;
  localparam logic [2:0] CONV_MODE_C = 3'h3;
  localparam logic [2:0] CONV_HALF_X = 3'h7;  // x size counts pixel pairs
  localparam logic [1:0] DMA_OFF = 2'h0;
  localparam logic [1:0] DMA_ENTRY = 2'h3;  // data arrives through the entry port

  typedef enum logic {CV_IDLE, CV_RUN} conv_st_t;

  // one word bound for graphics memory
  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } mem_wr_t;

  // true for the four codes that start a conversion
  function automatic logic is_conv(input logic [2:0] mode);
    is_conv = (mode == CONV_MODE_A) || (mode == CONV_MODE_B) ||
              (mode == CONV_MODE_C) || (mode == CONV_HALF_X);
  endfunction

endpackage

// ==== rtl/image_xfer_regs.sv ====
`timescale 1ns/1ps
module image_xfer_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [image_xfer_pkg::ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic axi_bvalid_out,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_bready_in,
  input wire logic [image_xfer_pkg::ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic axi_rvalid_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  input wire logic axi_rready_in,
  output logic mem_wr_valid_out,
  output image_xfer_pkg::mem_wr_t mem_wr_out,
  input wire logic mem_wr_ready_in,
  output logic [image_xfer_pkg::DMA_HI_W+image_xfer_pkg::WORD_W-1:0] dma_word_count_out,
  output logic [1:0] dma_mode_out,
  output logic [2:0] conv_mode_out,
  output logic conv_busy_out
);
  import image_xfer_pkg::*;

  // ***********************************
  // state
  // ***********************************
  typedef struct packed {
    logic awready;  // write address channel open
    logic wready;  // write data channel open
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_got;  // address held, waiting for data
    logic w_got;  // data held, waiting for address
    logic [IDX_W-1:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [DEST_HI_W-1:0] dest_hi;  // address A22..A16
    logic [DEST_LO_W-1:0] dest_lo;  // address A15..A1
    logic [SIZE_X_W-1:0] xsize;
    logic [SIZE_Y_W-1:0] ysize;
    logic [DMA_HI_W-1:0] dma_hi;
    logic [WORD_W-1:0] dma_lo;
    logic [WORD_W-1:0] entry;  // last word written to the entry port
    logic [2:0] conv_mode;
    logic [1:0] dma_mode;
    conv_st_t st;
    logic [PTR_W-1:0] ptr;  // internal store address
    logic [PIX_W-1:0] px_in;  // pixels accepted at the entry port
    logic [PIX_W-1:0] px_out;  // pixels stored to memory
    logic ovalid;  // output stage holds a word
    mem_wr_t odata;
  } regs_st_t;

  regs_st_t q;
  regs_st_t d;

  // ***********************************
  // decode helpers
  // ***********************************
  // any index that answers okay
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_CTRL, IDX_DEST_HI, IDX_DEST_LO, IDX_SIZE_X, IDX_SIZE_Y,
      IDX_ENTRY, IDX_DMA_HI, IDX_DMA_LO: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // readback value; unused bits and the entry port read as zero
  function automatic logic [WORD_W-1:0] reg_val(input regs_st_t s,
                                                input logic [IDX_W-1:0] idx);
    reg_val = REG_RST;
    case (idx)
      IDX_CTRL: begin
        reg_val[CTRL_CONV_LSB +: 3] = s.conv_mode;
        reg_val[CTRL_DMA_LSB +: 2] = s.dma_mode;
        reg_val[CTRL_BUSY_BIT] = (s.st == CV_RUN);
      end
      IDX_DEST_HI: reg_val[DEST_HI_W-1:0] = s.dest_hi;
      IDX_DEST_LO: reg_val[DEST_LO_LSB +: DEST_LO_W] = s.dest_lo;
      IDX_SIZE_X: reg_val[SIZE_X_W-1:0] = s.xsize;
      IDX_SIZE_Y: reg_val[SIZE_Y_W-1:0] = s.ysize;
      IDX_DMA_HI: reg_val[DMA_HI_W-1:0] = s.dma_hi;
      IDX_DMA_LO: reg_val = s.dma_lo;
      default: reg_val = REG_RST;
    endcase
  endfunction

  // byte-lane merge of the low two lanes
  function automatic logic [WORD_W-1:0] merge16(input logic [WORD_W-1:0] old,
                                                input logic [WORD_W-1:0] nw,
                                                input logic [1:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = nw[15:8];
    end
  endfunction

  // ***********************************
  // combinational terms
  // ***********************************
  logic half_x;  // mode 111: x size counts pixel pairs
  logic [PIX_W-1:0] prod;
  logic [PIX_W-1:0] target;  // pixels to store
  logic [PIX_W-1:0] step;  // pixels carried by one word
  logic entry_ok;  // entry port currently accepts words
  logic wr_entry;
  logic wr_dest;
  logic wr_dma;
  logic do_wr;  // held write is applied this cycle
  logic start;
  logic push;
  logic pop;
  logic store;
  logic [WORD_W-1:0] wcur;
  logic [WORD_W-1:0] wval;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic stage_free;

  // size is read live; the host keeps it still while a conversion runs
  assign half_x = (q.conv_mode == CONV_HALF_X);
  assign prod = PIX_W'(q.xsize) * PIX_W'(q.ysize);
  assign target = half_x ? {prod[PIX_W-2:0], 1'b0} : prod;
  assign step = half_x ? PIX_W'(2) : PIX_W'(1);
  // words beyond the image are dropped so nothing trails into a stale pointer
  assign entry_ok = (q.st == CV_RUN) && (q.px_in < target);
  assign wr_entry = (q.widx == IDX_ENTRY);
  assign wr_dest = (q.widx == IDX_DEST_HI) || (q.widx == IDX_DEST_LO);
  assign wr_dma = (q.widx == IDX_DMA_HI) || (q.widx == IDX_DMA_LO);
  // a full fifo holds the write response back, which stalls the host
  assign do_wr = q.aw_got && q.w_got && !q.bvalid &&
                 !(wr_entry && entry_ok && !fifo_in_ready);
  assign wcur = wr_entry ? q.entry : reg_val(q, q.widx);
  assign wval = merge16(wcur, q.wdata[WORD_W-1:0], q.wstrb[1:0]);
  assign start = do_wr && (q.widx == IDX_CTRL) && (q.st == CV_IDLE) &&
                 is_conv(wval[CTRL_CONV_LSB +: 3]);
  assign push = do_wr && wr_entry && entry_ok;
  assign store = q.ovalid && mem_wr_ready_in;
  assign stage_free = !q.ovalid || mem_wr_ready_in;
  assign pop = fifo_out_valid && stage_free;

  // ***********************************
  // image word buffer
  // ***********************************
  stream_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) stream_fifo_inst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push),
    .in_data_in(wval),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(stage_free)
  );

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    d = q;
    // write address and data are taken independently
    if (q.awready && axi_awvalid_in) begin
      d.awready = 1'b0;
      d.aw_got = 1'b1;
      d.widx = axi_awaddr_in[ADDR_W-1:2];
    end
    if (q.wready && axi_wvalid_in) begin
      d.wready = 1'b0;
      d.w_got = 1'b1;
      d.wdata = axi_wdata_in;
      d.wstrb = axi_wstrb_in;
    end
    // reopen a channel once nothing is held and no response waits
    if (!q.awready && !q.aw_got && !q.bvalid) begin
      d.awready = 1'b1;
    end
    if (!q.wready && !q.w_got && !q.bvalid) begin
      d.wready = 1'b1;
    end
    if (q.bvalid && axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    // apply a held write; unused bits are dropped by the field widths
    if (do_wr) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.widx) ? RESP_OKAY : RESP_SLVERR;
      case (q.widx)
        IDX_CTRL: begin
          // mode fields are frozen while a conversion runs
          if (q.st == CV_IDLE) begin
            d.conv_mode = wval[CTRL_CONV_LSB +: 3];
            d.dma_mode = wval[CTRL_DMA_LSB +: 2];
          end
        end
        IDX_DEST_HI: d.dest_hi = wval[DEST_HI_W-1:0];
        IDX_DEST_LO: d.dest_lo = wval[DEST_LO_LSB +: DEST_LO_W];
        IDX_SIZE_X: d.xsize = wval[SIZE_X_W-1:0];
        IDX_SIZE_Y: d.ysize = wval[SIZE_Y_W-1:0];
        IDX_DMA_HI: d.dma_hi = wval[DMA_HI_W-1:0];
        IDX_DMA_LO: d.dma_lo = wval;
        IDX_ENTRY: d.entry = wval;
        default: d.bresp = RESP_SLVERR;
      endcase
    end
    // read: one cycle from address to data
    if (!q.arready && !q.rvalid) begin
      d.arready = 1'b1;
    end
    if (q.arready && axi_arvalid_in) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rdata = {16'h0000, reg_val(q, axi_araddr_in[ADDR_W-1:2])};
      d.rresp = is_mapped(axi_araddr_in[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rvalid && axi_rready_in) begin
      d.rvalid = 1'b0;
    end
    // conversion start: the pointer takes a copy, the registers stay put
    if (start) begin
      d.st = CV_RUN;
      d.ptr = {q.dest_hi, q.dest_lo};
      d.px_in = '0;
      d.px_out = '0;
    end
    if (push) begin
      d.px_in = q.px_in + step;
    end
    // output stage: a popped word gets the pointer, which then moves on
    if (store) begin
      d.ovalid = 1'b0;
      d.px_out = q.px_out + step;
    end
    if (pop) begin
      d.ovalid = 1'b1;
      d.odata.addr = q.ptr;
      d.odata.data = fifo_out_data;
      d.ptr = q.ptr + PTR_W'(1);
    end
    // end of image: clear the mode, an entry-routed dma setting with it
    if ((q.st == CV_RUN) && (d.px_out >= target)) begin
      d.st = CV_IDLE;
      d.conv_mode = CONV_OFF;
      if (q.dma_mode == DMA_ENTRY) begin
        d.dma_mode = DMA_OFF;
      end
    end
  end

  // register the whole state; reset clears every register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign axi_awready_out = q.awready;
  assign axi_wready_out = q.wready;
  assign axi_bvalid_out = q.bvalid;
  assign axi_bresp_out = q.bresp;
  assign axi_arready_out = q.arready;
  assign axi_rvalid_out = q.rvalid;
  assign axi_rdata_out = q.rdata;
  assign axi_rresp_out = q.rresp;
  assign mem_wr_valid_out = q.ovalid;
  assign mem_wr_out = q.odata;
  assign dma_word_count_out = {q.dma_hi, q.dma_lo};
  assign dma_mode_out = q.dma_mode;
  assign conv_mode_out = q.conv_mode;
  assign conv_busy_out = (q.st == CV_RUN);

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_last_store;
    (q.st == CV_RUN) && store && ((q.px_out + step) >= target);
  endsequence
  sequence s_idle_clear;
    (q.st == CV_IDLE) && (q.conv_mode == CONV_OFF);
  endsequence
  property p_start_ptr;
    start |=> (q.ptr == {$past(q.dest_hi), $past(q.dest_lo)}) && (q.st == CV_RUN);
  endproperty
  a_start_ptr: assert property (p_start_ptr)
    else $error("pointer not loaded from destination at start");
  property p_dest_hold;
    !(do_wr && wr_dest) |=> $stable(q.dest_hi) && $stable(q.dest_lo);
  endproperty
  a_dest_hold: assert property (p_dest_hold)
    else $error("destination register moved without a write");
  property p_reset_clear;
    disable iff (1'b0)
    $rose(rstn_in) |-> (q.dest_hi == '0) && (q.dest_lo == '0) &&
      (q.xsize == '0) && (q.ysize == '0) && (q.entry == '0) &&
      (q.dma_hi == '0) && (q.dma_lo == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("register not zero after reset");
  // the step is taken from the mode that was live at the store, since the last
  // store clears the mode in the same edge
  property p_step;
    ((q.st == CV_RUN) && store) |=>
      (q.px_out == $past(q.px_out) + ($past(half_x) ? PIX_W'(2) : PIX_W'(1)));
  endproperty
  a_step: assert property (p_step)
    else $error("pixel count step wrong for mode");
  property p_ptr_adv;
    pop |=> (q.ptr == PTR_W'($past(q.ptr) + 1)) && (q.odata.addr == $past(q.ptr));
  endproperty
  a_ptr_adv: assert property (p_ptr_adv)
    else $error("pointer did not advance by one word");
  property p_finish;
    s_last_store |=> s_idle_clear;
  endproperty
  a_finish: assert property (p_finish)
    else $error("mode not cleared after last stored word");
  // an accepted entry word must sit in the buffer one cycle later
  property p_entry_push;
    (do_wr && wr_entry && entry_ok) |=> fifo_out_valid && (q.entry == $past(wval));
  endproperty
  a_entry_push: assert property (p_entry_push)
    else $error("entry word not taken");
  // while idle nothing may wait in the buffer or the output stage
  property p_idle_drop;
    (q.st == CV_IDLE) |-> !push && !fifo_out_valid && !q.ovalid;
  endproperty
  a_idle_drop: assert property (p_idle_drop)
    else $error("entry word taken with no conversion active");
  property p_dma_hold;
    !(do_wr && wr_dma) |=> $stable(dma_word_count_out);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("dma word count changed without a write");
  property p_dma_clear;
    (s_last_store and (q.dma_mode == DMA_ENTRY)) |=> (q.dma_mode == DMA_OFF);
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("entry-routed dma mode not cleared at end");
  property p_bresp;
    do_wr |=> q.bvalid && !q.aw_got && !q.w_got;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing after applied write");
endmodule

// ==== rtl/stream_fifo.sv ====
`timescale 1ns/1ps
module stream_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  // ***********************************
  // state
  // ***********************************
  localparam int AW = $clog2(DEPTH);  // depth is taken as a power of two

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // flip-flop storage
    logic [AW-1:0] wp;  // write index
    logic [AW-1:0] rp;  // read index
    logic [AW:0] cnt;  // words held
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic push;
  logic pop;

  // full and empty come straight from the count, so no slot is wasted
  assign in_ready_out = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = q.mem[q.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // next state: push and pop may happen in the same cycle
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - (AW+1)'(1);
    end
  end

  // register the whole state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// ==== sim/gfx_mem_sink.sv ====
`timescale 1ns/1ps
// ***********************************
// graphics memory stand-in
// ***********************************
module gfx_mem_sink
  import image_xfer_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic valid_in,
  input wire image_xfer_pkg::mem_wr_t wr_in,
  input wire logic stall_in,
  output logic ready_out
);
  logic [PTR_W-1:0] addr_q [0:63];  // word address of each stored word, in arrival order
  logic [WORD_W-1:0] data_q [0:63];  // data of each stored word
  int count_q;  // words stored since reset

  // a stalled memory holds ready low for as long as the bench asks
  assign ready_out = !stall_in;

  // record every word at the edge where valid and ready meet
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_q <= 0;
    end else if (valid_in && ready_out) begin
      addr_q[count_q] <= wr_in.addr;
      data_q[count_q] <= wr_in.data;
      count_q <= count_q + 1;
    end
  end
endmodule

// ==== sim/test_image_transfer_control_regs.sv ====
`timescale 1ns/1ps
module test_image_transfer_control_regs;
  import image_xfer_pkg::*;
  // ***********************************
  // stimulus, wiring and counters
  // ***********************************
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [ADDR_W-1:0] aw_addr = '0, ar_addr = '0;
  logic aw_valid = 1'b0, w_valid = 1'b0, ar_valid = 1'b0, stall_q = 1'b0;
  logic [31:0] w_data = '0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, mem_valid, mem_ready, busy;
  logic [1:0] b_resp, r_resp, dma_mode;
  logic [31:0] r_data;
  logic [2:0] conv_mode;
  mem_wr_t mem_wr;
  logic [DMA_HI_W+WORD_W-1:0] dma_count;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int pushed = 0;
  // destination made of high word 16'h0005 and low word 16'h1234 (bit 0 unused)
  localparam logic [PTR_W-1:0] BASE = {7'h05, 15'h091A};

  always #2.5 clk_in = ~clk_in;

  image_xfer_regs image_xfer_regs_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .axi_awaddr_in(aw_addr), .axi_awvalid_in(aw_valid), .axi_awready_out(aw_ready),
    .axi_wdata_in(w_data), .axi_wstrb_in(4'h3), .axi_wvalid_in(w_valid),
    .axi_wready_out(w_ready), .axi_bvalid_out(b_valid), .axi_bresp_out(b_resp),
    .axi_bready_in(1'b1), .axi_araddr_in(ar_addr), .axi_arvalid_in(ar_valid),
    .axi_arready_out(ar_ready), .axi_rvalid_out(r_valid), .axi_rdata_out(r_data),
    .axi_rresp_out(r_resp), .axi_rready_in(1'b1), .mem_wr_valid_out(mem_valid),
    .mem_wr_out(mem_wr), .mem_wr_ready_in(mem_ready), .dma_word_count_out(dma_count),
    .dma_mode_out(dma_mode), .conv_mode_out(conv_mode), .conv_busy_out(busy));

  gfx_mem_sink gfx_mem_sink_inst (.clk_in(clk_in), .rstn_in(rstn_in), .valid_in(mem_valid),
    .wr_in(mem_wr), .stall_in(stall_q), .ready_out(mem_ready));

  // ***********************************
  // checking and closing
  // ***********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang anywhere ends the run; the whole sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ***********************************
  // register bus tasks
  // ***********************************
  // address and data offered together, each dropped at its own handshake edge
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d, input logic [1:0] er);
    aw_addr <= {idx, 2'b00};
    w_data <= {16'h0000, d};
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
      if (b_valid) break;
    end
    check(32'(b_resp), 32'(er));
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] ed, input logic [1:0] er);
    ar_addr <= {idx, 2'b00};
    ar_valid <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
      if (r_valid) break;
    end
    check(r_data, ed);
    check(32'(r_resp), 32'(er));
  endtask

  // ***********************************
  // one whole conversion, optionally against a stalled memory
  // ***********************************
  task automatic run_conv(input logic [2:0] mode, input int x, input int y, input logic stl);
    int first;
    int words;
    first = gfx_mem_sink_inst.count_q;
    words = x * y;
    pushed = 0;
    wr(IDX_SIZE_X, 16'(x), RESP_OKAY);
    wr(IDX_SIZE_Y, 16'(y), RESP_OKAY);
    stall_q <= stl;
    wr(IDX_CTRL, {10'h000, 2'b11, 1'b0, mode}, RESP_OKAY);
    // sizes and destination stay untouched until the mode clears
    fork
      for (int k = 0; k < words; k++) begin
        wr(IDX_ENTRY, 16'hA000 + 16'(k), RESP_OKAY);
        pushed++;
      end
      if (stl) begin
        repeat (400) @(posedge clk_in);
        check(32'((pushed >= FIFO_DEPTH) && (pushed < words)), 32'h1);
        rd(IDX_CTRL, {23'h0, 1'b1, 2'b00, 2'b11, 1'b0, mode}, RESP_OKAY);
        stall_q <= 1'b0;
      end
    join
    for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk_in);
    // a word past the end of the image must be dropped
    wr(IDX_ENTRY, 16'hFFFF, RESP_OKAY);
    repeat (10) @(posedge clk_in);
    check(32'(gfx_mem_sink_inst.count_q - first), 32'(words));
    for (int k = 0; k < words; k++) begin
      check(32'(gfx_mem_sink_inst.addr_q[first + k]), 32'(BASE) + 32'(k));
      check(32'(gfx_mem_sink_inst.data_q[first + k]), 32'hA000 + 32'(k));
    end
    rd(IDX_DEST_HI, 32'h0005, RESP_OKAY);
    rd(IDX_DEST_LO, 32'h1234, RESP_OKAY);
    rd(IDX_DMA_LO, 32'h0345, RESP_OKAY);
    rd(IDX_CTRL, 32'h0, RESP_OKAY);
    check(32'({conv_mode, dma_mode, busy}), 32'h0);
    $display("test conversion in mode %0d done", mode);
  endtask

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    logic [IDX_W-1:0] idx_list [0:5];
    logic [15:0] mask_list [0:5];
    idx_list = '{IDX_DEST_HI, IDX_DEST_LO, IDX_SIZE_X, IDX_SIZE_Y, IDX_DMA_HI, IDX_DMA_LO};
    mask_list = '{16'h007F, 16'hFFFE, 16'h07FF, 16'h03FF, 16'h0007, 16'hFFFF};
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    // everything reads zero straight after reset
    foreach (idx_list[i]) rd(idx_list[i], 32'h0, RESP_OKAY);
    rd(IDX_ENTRY, 32'h0, RESP_OKAY);
    check(32'(dma_count), 32'h0);
    $display("test reset values done");
    // every field bit set, unused bits kept at zero as the host must
    foreach (idx_list[i]) begin
      wr(idx_list[i], mask_list[i], RESP_OKAY);
      rd(idx_list[i], 32'(mask_list[i]), RESP_OKAY);
    end
    check(32'(dma_count), 32'h0007FFFF);
    wr(10'h3FF, 16'h0000, RESP_SLVERR);
    rd(10'h3FF, 32'h0, RESP_SLVERR);
    rd(IDX_ENTRY, 32'h0, RESP_OKAY);
    // an entry word with no conversion running goes nowhere
    wr(IDX_ENTRY, 16'h1111, RESP_OKAY);
    repeat (10) @(posedge clk_in);
    check(32'(gfx_mem_sink_inst.count_q), 32'h0);
    $display("test field widths done");
    wr(IDX_DEST_HI, 16'h0005, RESP_OKAY);
    wr(IDX_DEST_LO, 16'h1234, RESP_OKAY);
    wr(IDX_DMA_HI, 16'h0000, RESP_OKAY);
    wr(IDX_DMA_LO, 16'h0345, RESP_OKAY);
    run_conv(3'h1, 6, 6, 1'b1);
    run_conv(3'h2, 2, 1, 1'b0);
    run_conv(3'h3, 2, 1, 1'b0);
    run_conv(3'h7, 2, 1, 1'b0);
    final_report();
  end
endmodule
